// File: src/dba_ctrl.sv
// Functional notes
// - Burst length loaded through base mode bits.
// - Burst type loaded through base bit three.
// - Never truncate a length four burst.
// - No burst stop; bursts always run out.
// - Read: select, column low; row, write high.
// - Latencies programmed via base and extended loads.
// - Write: select, column, write low; row high.
// - Write latency is read latency minus one.
// - Write strobe preamble one clock before latency.
// - Wait write recovery before next command.
// - One mask bit per byte, data timing.
// - Precharge: select, row, write low; column high.
// - A10 on read or write requests auto precharge.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module dba_ctrl #(
	parameter int REC_CK = 4
) (
	// APB slave.
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Memory clock and command pins.
	output logic                              ck,
	output logic                              ck_n,
	output logic                              cs_n,
	output logic                              ras_n,
	output logic                              cas_n,
	output logic                              we_n,
	output logic      [dba_pkg::BANK_W-1:0]   ba,
	output logic      [dba_pkg::ADDR_W-1:0]   addr,
	// Data, strobe and mask pins.
	input  wire logic [dba_pkg::DQ_W-1:0]     dq_in,
	output logic      [dba_pkg::DQ_W-1:0]     dq_out,
	output logic                              dq_oe,
	input  wire logic                         dqs_in,
	output logic                              dqs_out,
	output logic                              dqs_oe,
	output logic                              dqs_n_out,
	output logic                              dqs_n_oe,
	output logic      [dba_pkg::MASK_W-1:0]   byte_write_mask
);
	typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_HOLD, ST_DATA, ST_RECOV} dba_state_t;

	dba_state_t                  state_reg;
	logic [2:0]                  op_reg;
	logic [6:0]                  e_reg;
	logic [7:0]                  rec_reg;
	logic                        done_reg;
	logic [1:0]                  ph_reg;
	logic [dba_pkg::ADDR_W-1:0]  col_reg;
	logic [dba_pkg::BANK_W-1:0]  bank_reg;
	logic [dba_pkg::CFG_W-1:0]   cfg_reg;
	logic [dba_pkg::MASK_W*dba_pkg::SLOTS-1:0] mask_reg;
	logic [dba_pkg::DQ_W-1:0]    wslot_reg [dba_pkg::SLOTS];
	logic [dba_pkg::DQ_W-1:0]    rslot_reg [dba_pkg::SLOTS];
	logic [3:0]                  rd_cnt_reg;
	logic                        dqs_d_reg;
	logic [dba_pkg::DQ_W:0]      in_s;
	logic [dba_pkg::DQ_W-1:0]    dq_s;
	logic                        dqs_s;

	logic                        rise_ev;
	logic                        fall_ev;
	logic                        edge_ev;
	logic                        mid_ev;
	logic                        wr_acc;
	logic                        cmd_go;
	logic                        addr_ok;
	logic [31:0]                 rd_mux;
	logic                        bl8;
	logic                        ilv;
	logic                        diff;
	logic [dba_pkg::LAT_W-1:0]   cl;
	logic [dba_pkg::LAT_W-1:0]   al_eff;
	logic [6:0]                  rl2;
	logic [6:0]                  wl2;
	logic [6:0]                  bl_beats;
	logic [6:0]                  e_next;
	logic [6:0]                  wbeat;
	logic [6:0]                  lvl_diff;
	logic [2:0]                  wslot_idx;
	logic [2:0]                  rslot_idx;
	logic                        wr_act;
	logic                        rd_act;
	logic [dba_pkg::ADDR_W-1:0]  cmd_addr;
	logic [dba_pkg::BANK_W-1:0]  cmd_ba;
	logic [2:0]                  cmd_pat;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	dba_sync #(.W(dba_pkg::DQ_W + 1)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({dqs_in, dq_in}),
		.q_reg (in_s)
	);
	assign dqs_s = in_s[dba_pkg::DQ_W];
	assign dq_s  = in_s[dba_pkg::DQ_W-1:0];

	// Configuration decode and latency arithmetic.
	always_comb begin
		bl8      = cfg_reg[dba_pkg::CFG_BL8_BIT];
		ilv      = cfg_reg[dba_pkg::CFG_ILV_BIT];
		diff     = cfg_reg[dba_pkg::CFG_DIFF_BIT];
		cl       = cfg_reg[dba_pkg::CFG_CL_LSB +: dba_pkg::LAT_W];
		al_eff   = cfg_reg[dba_pkg::CFG_AL_LSB +: dba_pkg::LAT_W];
		if (al_eff > dba_pkg::AL_MAX) begin
			al_eff = dba_pkg::AL_MAX;
		end
		rl2      = {3'h0, 4'({1'b0, al_eff} + {1'b0, cl})} << 1;
		wl2      = rl2 - (dba_pkg::EDGE_STEP << 1);
		bl_beats = bl8 ? dba_pkg::BL_LONG : dba_pkg::BL_SHORT;
		e_next   = e_reg + dba_pkg::EDGE_STEP;
		wbeat    = e_reg - wl2;
		lvl_diff = e_next - wl2;
		wslot_idx = dba_pkg::burst_slot(col_reg[2:0], wbeat[2:0], bl8, ilv);
		rslot_idx = dba_pkg::burst_slot(col_reg[2:0], rd_cnt_reg[2:0], bl8, ilv);
	end

	assign rise_ev = (ph_reg == dba_pkg::PH_RISE);
	assign fall_ev = (ph_reg == dba_pkg::PH_FALL);
	assign edge_ev = rise_ev || fall_ev;
	assign mid_ev  = !edge_ev;
	assign wr_act  = (state_reg == ST_HOLD || state_reg == ST_DATA) && op_reg == dba_pkg::OP_WRITE;
	assign rd_act  = (state_reg == ST_DATA) && op_reg == dba_pkg::OP_READ;
	assign wr_acc  = psel && penable && pwrite && pready;
	assign cmd_go  = wr_acc && paddr == dba_pkg::OFF_CMD && state_reg == ST_IDLE
		&& pwdata[2:0] != dba_pkg::OP_NONE && pwdata[2:0] <= dba_pkg::OP_EXT;

	// Link clock divider: four bus clocks per memory clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_reg <= 2'h0;
			ck     <= 1'b0;
			ck_n   <= 1'b1;
		end else begin
			ph_reg <= ph_reg + 2'h1;
			if (rise_ev) begin
				ck   <= 1'b1;
				ck_n <= 1'b0;
			end else if (fall_ev) begin
				ck   <= 1'b0;
				ck_n <= 1'b1;
			end
		end
	end

	// APB register decode.
	always_comb begin
		addr_ok = paddr[1:0] == 2'h0 && (paddr <= dba_pkg::OFF_MASK
			|| paddr[7:4] == dba_pkg::WIN_WDATA || paddr[7:4] == dba_pkg::WIN_RDATA);
		rd_mux = 32'h0;
		case (paddr)
			dba_pkg::OFF_CMD:    rd_mux = {29'h0, op_reg};
			dba_pkg::OFF_ADDR:   rd_mux = {17'h0, bank_reg, col_reg};
			dba_pkg::OFF_CFG:    rd_mux = {23'h0, cfg_reg};
			dba_pkg::OFF_STATUS: rd_mux = {30'h0, done_reg, state_reg != ST_IDLE};
			dba_pkg::OFF_MASK:   rd_mux = {16'h0, mask_reg};
			default: begin
				if (paddr[7:4] == dba_pkg::WIN_WDATA) begin
					rd_mux = {wslot_reg[{paddr[3:2], 1'b1}], wslot_reg[{paddr[3:2], 1'b0}]};
				end else if (paddr[7:4] == dba_pkg::WIN_RDATA) begin
					rd_mux = {rslot_reg[{paddr[3:2], 1'b1}], rslot_reg[{paddr[3:2], 1'b0}]};
				end
			end
		endcase
	end

	// APB answer: one wait-free access phase after every setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	// Software registers; configuration is frozen while a command runs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_reg  <= '0;
			bank_reg <= '0;
			cfg_reg  <= dba_pkg::CFG_RST;
			mask_reg <= '0;
			for (int i = 0; i < dba_pkg::SLOTS; i++) begin
				wslot_reg[i] <= '0;
			end
		end else if (wr_acc) begin
			if (paddr == dba_pkg::OFF_ADDR) begin
				{bank_reg, col_reg} <= pwdata[dba_pkg::BANK_W+dba_pkg::ADDR_W-1:0];
			end
			if (paddr == dba_pkg::OFF_CFG && state_reg == ST_IDLE) begin
				cfg_reg <= pwdata[dba_pkg::CFG_W-1:0];
			end
			if (paddr == dba_pkg::OFF_MASK) begin
				mask_reg <= pwdata[dba_pkg::MASK_W*dba_pkg::SLOTS-1:0];
			end
			if (paddr[7:4] == dba_pkg::WIN_WDATA && paddr[1:0] == 2'h0) begin
				wslot_reg[{paddr[3:2], 1'b0}] <= pwdata[15:0];
				wslot_reg[{paddr[3:2], 1'b1}] <= pwdata[31:16];
			end
		end
	end

	// Command sequencer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			op_reg    <= dba_pkg::OP_NONE;
			e_reg     <= 7'h0;
			rec_reg   <= 8'h0;
			done_reg  <= 1'b0;
		end else begin
			if (edge_ev) begin
				e_reg <= e_next;
			end
			case (state_reg)
				ST_IDLE: begin
					if (cmd_go) begin
						state_reg <= ST_ISSUE;
						op_reg    <= pwdata[2:0];
						done_reg  <= 1'b0;
					end
				end
				ST_ISSUE: begin
					if (fall_ev) begin
						state_reg <= ST_HOLD;
						e_reg     <= 7'h0;
					end
				end
				ST_HOLD: begin
					if (fall_ev) begin
						if (op_reg == dba_pkg::OP_READ || op_reg == dba_pkg::OP_WRITE) begin
							state_reg <= ST_DATA;
						end else begin
							state_reg <= ST_RECOV;
							rec_reg   <= dba_pkg::REC_SHORT;
						end
					end
				end
				ST_DATA: begin
					if (op_reg == dba_pkg::OP_WRITE && edge_ev && e_next == wl2 + bl_beats + 7'h02) begin
						state_reg <= ST_RECOV;
						rec_reg   <= 8'(REC_CK);
					end else if (op_reg == dba_pkg::OP_READ && rd_cnt_reg == bl_beats[3:0]) begin
						state_reg <= ST_RECOV;
						rec_reg   <= dba_pkg::REC_SHORT;
					end
				end
				ST_RECOV: begin
					if (rise_ev) begin
						if (rec_reg <= dba_pkg::REC_SHORT) begin
							state_reg <= ST_IDLE;
							done_reg  <= 1'b1;
						end else begin
							rec_reg <= rec_reg - 8'h01;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Command pin values for the pending operation.
	always_comb begin
		cmd_addr = col_reg;
		cmd_ba   = bank_reg;
		cmd_pat  = 3'h7;
		case (op_reg)
			dba_pkg::OP_READ:  cmd_pat = 3'h5;
			dba_pkg::OP_WRITE: cmd_pat = 3'h4;
			dba_pkg::OP_PRE:   cmd_pat = 3'h2;
			dba_pkg::OP_BASE: begin
				cmd_pat  = 3'h0;
				cmd_ba   = dba_pkg::BA_BASE;
				cmd_addr = '0;
				cmd_addr[dba_pkg::MR_BL_LSB +: 3] = bl8 ? dba_pkg::BL_CODE8 : dba_pkg::BL_CODE4;
				cmd_addr[dba_pkg::MR_BT_BIT] = ilv;
				cmd_addr[dba_pkg::MR_CL_LSB +: dba_pkg::LAT_W] = cl;
			end
			dba_pkg::OP_EXT: begin
				cmd_pat  = 3'h0;
				cmd_ba   = dba_pkg::BA_EXT;
				cmd_addr = '0;
				cmd_addr[dba_pkg::EMR_AL_LSB +: dba_pkg::LAT_W] = al_eff;
				cmd_addr[dba_pkg::EMR_DQSN_OFF_BIT] = !diff;
			end
			default: cmd_pat = 3'h7;
		endcase
	end

	// Command pins change on the falling memory clock edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_n  <= 1'b1;
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			we_n  <= 1'b1;
			ba    <= '0;
			addr  <= '0;
		end else if (fall_ev && state_reg == ST_ISSUE) begin
			cs_n  <= 1'b0;
			{ras_n, cas_n, we_n} <= cmd_pat;
			ba    <= cmd_ba;
			addr  <= cmd_addr;
		end else if (fall_ev && state_reg == ST_HOLD) begin
			cs_n  <= 1'b1;
			{ras_n, cas_n, we_n} <= 3'h7;
		end
	end

	// Write burst: data one bus clock ahead of each strobe edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_out          <= '0;
			dq_oe           <= 1'b0;
			byte_write_mask <= '0;
			dqs_out         <= 1'b0;
			dqs_oe          <= 1'b0;
			dqs_n_out       <= 1'b1;
			dqs_n_oe        <= 1'b0;
		end else if (wr_act) begin
			if (mid_ev && e_reg >= wl2 && wbeat < bl_beats) begin
				dq_out <= wslot_reg[wslot_idx];
				dq_oe  <= 1'b1;
				byte_write_mask <= mask_reg[{wslot_idx, 1'b0} +: dba_pkg::MASK_W];
			end
			if (edge_ev) begin
				if (e_next == wl2 - dba_pkg::EDGE_STEP) begin
					dqs_oe    <= 1'b1;
					dqs_out   <= 1'b0;
					dqs_n_oe  <= diff;
					dqs_n_out <= 1'b1;
				end else if (e_next > wl2 && e_next <= wl2 + bl_beats) begin
					dqs_out   <= lvl_diff[0];
					dqs_n_out <= !lvl_diff[0];
				end else if (e_next == wl2 + bl_beats + 7'h02) begin
					dq_oe           <= 1'b0;
					byte_write_mask <= '0;
					dqs_oe          <= 1'b0;
					dqs_n_oe        <= 1'b0;
				end
			end
		end
	end

	// Read burst: one beat per synchronised strobe edge after the preamble.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_cnt_reg <= 4'h0;
			dqs_d_reg  <= 1'b0;
			for (int i = 0; i < dba_pkg::SLOTS; i++) begin
				rslot_reg[i] <= '0;
			end
		end else begin
			dqs_d_reg <= dqs_s;
			if (state_reg != ST_DATA) begin
				rd_cnt_reg <= 4'h0;
			end else if (rd_act && e_reg > rl2 && dqs_s != dqs_d_reg && rd_cnt_reg < bl_beats[3:0]) begin
				rslot_reg[rslot_idx] <= dq_s;
				rd_cnt_reg <= rd_cnt_reg + 4'h1;
			end
		end
	end

	// Helper: strobe edges while the write strobe is driven.
	logic [3:0] tog_cnt;
	logic       dqs_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_cnt <= 4'h0;
			dqs_q   <= 1'b0;
		end else begin
			dqs_q <= dqs_out;
			if (!dqs_oe) begin
				tog_cnt <= 4'h0;
			end else if (dqs_out != dqs_q) begin
				tog_cnt <= tog_cnt + 4'h1;
			end
		end
	end

	sequence s_preamble;
		(dqs_oe && !dqs_out) [*4];
	endsequence
	sequence s_first_beat;
		dqs_out && e_reg == wl2 + dba_pkg::EDGE_STEP;
	endsequence
	sequence s_cmd_ck;
		!cs_n [*4] ##1 cs_n;
	endsequence

	chk_read_pattern: assert property (state_reg == ST_ISSUE && fall_ev && op_reg == dba_pkg::OP_READ
		|=> !cs_n && ras_n && !cas_n && we_n) else $error("read pins wrong");
	chk_write_pattern: assert property (state_reg == ST_ISSUE && fall_ev && op_reg == dba_pkg::OP_WRITE
		|=> !cs_n && ras_n && !cas_n && !we_n && addr[dba_pkg::AUTO_PRE_BIT] == col_reg[dba_pkg::AUTO_PRE_BIT])
		else $error("write pins wrong");
	chk_pre_pattern: assert property (state_reg == ST_ISSUE && fall_ev && op_reg == dba_pkg::OP_PRE
		|=> !cs_n && !ras_n && cas_n && !we_n && ba == bank_reg) else $error("precharge pins wrong");
	chk_cmd_width: assert property ($fell(cs_n) |-> s_cmd_ck)
		else $error("command not one clock wide");
	chk_wr_preamble: assert property ($rose(dqs_oe) |-> s_preamble ##1 dqs_out)
		else $error("write preamble wrong");
	chk_wr_latency: assert property ($rose(dqs_oe) |-> ##4 s_first_beat)
		else $error("first write strobe off latency");
	chk_burst_edges: assert property (dqs_oe ##1 !dqs_oe |-> $past(tog_cnt) == bl_beats[3:0])
		else $error("strobe edge count wrong");
	chk_wr_recovery: assert property ($fell(dq_oe) |-> cs_n [*8])
		else $error("command inside write recovery");
	chk_bl_code: assert property (!cs_n && !ras_n && !cas_n && !we_n && ba == dba_pkg::BA_BASE
		|-> addr[2:0] == dba_pkg::BL_CODE4 || addr[2:0] == dba_pkg::BL_CODE8) else $error("bad burst length");
	chk_al_range: assert property (!cs_n && !ras_n && !cas_n && !we_n && ba == dba_pkg::BA_EXT
		|-> addr[dba_pkg::EMR_AL_LSB +: dba_pkg::LAT_W] <= dba_pkg::AL_MAX) else $error("additive latency too big");
	chk_diff_strobe: assert property (dqs_n_oe |-> diff && dqs_oe && dqs_n_out == !dqs_out)
		else $error("complement strobe wrong");
	chk_rd_no_mask: assert property (rd_act |-> byte_write_mask == '0 && !dq_oe && !dqs_oe)
		else $error("driving during read");
endmodule : dba_ctrl

// File: src/dba_pkg.sv
package dba_pkg;

	// Pin and storage widths.
	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int DQ_W   = 16;
	localparam int MASK_W = DQ_W / 8;
	localparam int SLOTS  = 8;
	localparam int LAT_W  = 3;
	localparam int CFG_W  = 9;

	// Register byte offsets on the APB side.
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_ADDR   = 8'h04;
	localparam logic [7:0] OFF_CFG    = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_MASK   = 8'h10;
	localparam logic [3:0] WIN_WDATA  = 4'h2;
	localparam logic [3:0] WIN_RDATA  = 4'h3;

	// Command codes written to the command register.
	localparam logic [2:0] OP_NONE  = 3'h0;
	localparam logic [2:0] OP_READ  = 3'h1;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam logic [2:0] OP_PRE   = 3'h3;
	localparam logic [2:0] OP_BASE  = 3'h4;
	localparam logic [2:0] OP_EXT   = 3'h5;

	// Configuration register fields and reset value.
	localparam int CFG_BL8_BIT  = 0;
	localparam int CFG_ILV_BIT  = 1;
	localparam int CFG_CL_LSB   = 2;
	localparam int CFG_AL_LSB   = 5;
	localparam int CFG_DIFF_BIT = 8;
	localparam logic [CFG_W-1:0] CFG_RST = 9'h10c;

	// Mode register address fields.
	localparam int MR_BL_LSB  = 0;
	localparam int MR_BT_BIT  = 3;
	localparam int MR_CL_LSB  = 4;
	localparam int EMR_AL_LSB = 3;
	localparam int EMR_DQSN_OFF_BIT = 10;
	localparam int AUTO_PRE_BIT = 10;
	localparam logic [2:0] BL_CODE4 = 3'h2;
	localparam logic [2:0] BL_CODE8 = 3'h3;
	localparam logic [BANK_W-1:0] BA_BASE = 2'h0;
	localparam logic [BANK_W-1:0] BA_EXT  = 2'h1;
	localparam logic [LAT_W-1:0] AL_MAX  = 3'h5;

	// Timing counts in link clock edges and cycles.
	localparam logic [6:0] BL_SHORT  = 7'h04;
	localparam logic [6:0] BL_LONG   = 7'h08;
	localparam logic [6:0] EDGE_STEP = 7'h01;
	localparam logic [7:0] REC_SHORT = 8'h01;
	localparam logic [1:0] PH_FALL   = 2'h1;
	localparam logic [1:0] PH_RISE   = 2'h3;

	// Column offset of a given beat inside the burst.
	function automatic logic [2:0] burst_slot(input logic [2:0] start, input logic [2:0] beat,
		input logic bl8, input logic ilv);
		logic [2:0] s;
		s = 3'h0;
		if (ilv) begin
			s = start ^ beat;
		end else begin
			s = {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
		end
		if (!bl8) begin
			s[2] = 1'b0;
		end
		return s;
	endfunction : burst_slot

endpackage : dba_pkg

// File: src/dba_sync.sv
`timescale 1ns/100ps
module dba_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Asynchronous input and its synchronised copy.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q_reg
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end
endmodule : dba_sync

// File: bench/dba_dev_model.sv
`timescale 1ns/100ps
module dba_dev_model (
	// Command pins.
	input  wire logic        ck,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [1:0]  ba,
	input  wire logic [12:0] addr,
	// Data wires and the model's own drive.
	input  wire logic [15:0] dq_w,
	input  wire logic        dqs_w,
	input  wire logic        dqs_oe,
	input  wire logic [1:0]  mask,
	output logic      [15:0] m_dq,
	output logic             m_dqs
);
	int          bl = 4, cl = 3, al = 0, nb = 0;
	logic        ilv = 1'b0, diff = 1'b1, ap = 1'b0, wr = 1'b0, rd_on = 1'b0;
	logic [3:0]  pre = 4'h0;
	logic [2:0]  st = 3'h0;
	logic [15:0] mem [8] = '{default: 16'h0000};
	realtime     tc = 0.0, wl_ns = 0.0;

	function automatic logic [2:0] col(input logic [2:0] s, input int k);
		logic [2:0] kk;
		logic [2:0] c;
		kk = 3'(k);
		c = ilv ? s ^ kk : {s[2] ^ kk[2], 2'(s[1:0] + kk[1:0])};
		if (bl == 4) c[2] = 1'b0;
		return c;
	endfunction : col

	// Released data lines show a changing pattern, the strobe the inverse of its last level.
	initial begin
		m_dq = 16'h0000;
		m_dqs = 1'b1;
	end
	always @(posedge ck) if (!rd_on) m_dq <= ~m_dq;

	task automatic rd_burst(input logic [2:0] s);
		repeat (al + cl - 1) @(posedge ck);
		rd_on = 1'b1;
		m_dqs = 1'b0;
		@(posedge ck);
		for (int k = 0; k < bl; k++) begin
			if (k > 0) @(ck);
			m_dq = mem[col(s, k)];
			m_dqs = !k[0];
		end
		@(ck);
		rd_on = 1'b0;
		m_dqs = 1'b1;
	endtask : rd_burst

	always @(posedge ck) begin
		if (!cs_n) begin
			case ({ras_n, cas_n, we_n})
				3'b000: if (ba == 2'h0) begin
					bl = (addr[2:0] == 3'h3) ? 8 : 4;
					ilv = addr[3];
					cl = addr[6:4];
				end else begin
					al = (addr[5:3] > 3'h5) ? 5 : addr[5:3];
					diff = !addr[10];
				end
				3'b101: begin
					ap = addr[10];
					fork
						rd_burst(addr[2:0]);
					join_none
				end
				3'b100: begin
					ap = addr[10];
					st = addr[2:0];
					nb = 0;
					wr = 1'b1;
					tc = $realtime;
				end
				3'b010: pre = addr[10] ? 4'hf : 4'(4'h1 << ba);
				default: ;
			endcase
		end
	end

	always @(dqs_w) begin
		if (wr && dqs_oe && (nb > 0 || dqs_w === 1'b1) && nb < bl) begin
			if (nb == 0) wl_ns = $realtime - tc;
			for (int b = 0; b < 2; b++) if (!mask[b]) mem[col(st, nb)][b*8 +: 8] = dq_w[b*8 +: 8];
			nb++;
		end
	end
endmodule : dba_dev_model

// File: bench/dba_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin mismatches++; \
	$display("wrong value at %0t: got %0h want %0h", $time, g, w); end end
module dba_ctrl_tb;
	localparam logic [8:0]  CFGS [4]   = '{9'h12d, 9'h012, 9'h1eb, 9'h054};
	localparam logic [2:0]  STARTS [4] = '{3'h5, 3'h3, 3'h6, 3'h2};
	localparam logic [15:0] MASKS [4]  = '{16'h0004, 16'h0000, 16'hc000, 16'h0020};

	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, ck, ck_n, cs_n, ras_n, cas_n, we_n;
	logic        dq_oe, dqs_out, dqs_oe, dqs_n_out, dqs_n_oe, m_dqs, n_seen = 1'b0;
	logic [1:0]  ba, bwm;
	logic [12:0] addr;
	logic [15:0] dq_out, m_dq, mx;
	logic [15:0] exp_m [8] = '{default: 16'h0000};
	int          mismatches = 0, tests_run = 0;
	wire  [15:0] dq_w = dq_oe ? dq_out : m_dq;
	wire         dqs_w = dqs_oe ? dqs_out : m_dqs;

	initial forever #12.5 pclk = ~pclk;
	always @(posedge pclk) if (dqs_n_oe === 1'b1) n_seen <= 1'b1;

	dba_ctrl #(.REC_CK(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ck(ck), .ck_n(ck_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
		.dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_w), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
		.dqs_n_out(dqs_n_out), .dqs_n_oe(dqs_n_oe), .byte_write_mask(bwm));

	dba_dev_model dev_u (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
		.addr(addr), .dq_w(dq_w), .dqs_w(dqs_w), .dqs_oe(dqs_oe), .mask(bwm), .m_dq(m_dq), .m_dqs(m_dqs));

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	// Each transfer ends with one idle cycle, so no signal is set twice in one step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// The answer is looked at mid-cycle, where it is settled for the next rising edge.
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) begin mismatches++; finish_test(); end
	endtask : apb

	task automatic run_cmd(input logic [2:0] op);
		int n;
		n = 0;
		apb(1'b1, dba_pkg::OFF_CMD, 32'(op));
		do begin
			apb(1'b0, dba_pkg::OFF_STATUS, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b10 && n < 400); // next command only after done
		if (n >= 400) begin mismatches++; finish_test(); end
	endtask : run_cmd

	function automatic logic [15:0] pat(input int c, input int j);
		return {4'(c), 4'(j), 4'(~c), 4'(~j)};
	endfunction : pat

	initial begin
		int bl;
		int cl;
		int al;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, dba_pkg::OFF_CFG, 32'h0);
		`CHK(rd[8:0], dba_pkg::CFG_RST)
		apb(1'b0, 8'h44, 32'h0);
		`CHK(err, 1'b1)
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, dba_pkg::OFF_CFG, 32'(CFGS[c]));
			run_cmd(dba_pkg::OP_BASE);
			run_cmd(dba_pkg::OP_EXT);
			bl = CFGS[c][0] ? 8 : 4;
			cl = CFGS[c][4:2];
			al = (CFGS[c][7:5] > 3'h5) ? 5 : CFGS[c][7:5];
			`CHK(dev_u.bl, bl)
			`CHK(dev_u.ilv, CFGS[c][1])
			`CHK(dev_u.cl, cl)
			`CHK(dev_u.al, al)
			`CHK(dev_u.diff, CFGS[c][8])
			for (int w = 0; w < 4; w++) apb(1'b1, {dba_pkg::WIN_WDATA, 4'(4 * w)}, {pat(c, 2*w+1), pat(c, 2*w)});
			apb(1'b1, dba_pkg::OFF_MASK, 32'(MASKS[c]));
			apb(1'b1, dba_pkg::OFF_ADDR, {17'h0, 2'(c), 13'h0400 | 13'(STARTS[c])});
			n_seen = 1'b0;
			run_cmd(dba_pkg::OP_WRITE);
			for (int j = 0; j < bl; j++) begin
				mx = {{8{MASKS[c][2*j+1]}}, {8{MASKS[c][2*j]}}};
				exp_m[j] = (exp_m[j] & mx) | (pat(c, j) & ~mx);
				`CHK(dev_u.mem[j], exp_m[j])
			end
			`CHK($rtoi(dev_u.wl_ns), (al + cl - 1) * 100)
			`CHK(dev_u.ap, 1'b1)
			`CHK(n_seen, CFGS[c][8])
			apb(1'b1, dba_pkg::OFF_ADDR, {17'h0, 2'(c), 10'h0, STARTS[c]});
			run_cmd(dba_pkg::OP_READ);
			`CHK(dev_u.ap, 1'b0)
			for (int w = 0; w < bl / 2; w++) begin
				apb(1'b0, {dba_pkg::WIN_RDATA, 4'(4 * w)}, 32'h0);
				`CHK(rd, {exp_m[2*w+1], exp_m[2*w]})
			end
		end
		for (int b = 0; b < 5; b++) begin
			apb(1'b1, dba_pkg::OFF_ADDR, (b == 4) ? 32'h0000_6400 : {17'h0, 2'(b), 13'h0});
			run_cmd(dba_pkg::OP_PRE);
			`CHK(dev_u.pre, (b == 4) ? 4'hf : 4'(4'h1 << b))
		end
		finish_test();
	end
endmodule : dba_ctrl_tb
